// file: press_contact_regs.svh
`ifndef PRESS_CONTACT_REGS_SVH
`define PRESS_CONTACT_REGS_SVH

// register byte offsets and control reset value
`define PCM_CTRL_OFS 8'h00
`define PCM_STATUS_OFS 8'h04
`define PCM_CTRL_RST 32'h0000_0000

// control field positions
`define PCM_CTRL_RUN 0
`define PCM_CTRL_UNIV 1
`define PCM_CTRL_SZ_EN 2
`define PCM_CTRL_FOOT_EN 3
`define PCM_CTRL_CLR_EN 4
`define PCM_CTRL_BYP_EN 5
`define PCM_CTRL_FLAG_EN 6
`define PCM_CTRL_PPC_RANGE 7
`define PCM_CTRL_MIN_LONG 8
`define PCM_CTRL_W 9

// timing
`define PCM_CLK_NS 20
`define PCM_MS_NS 1000000
`define PCM_TICK_CYCLES (`PCM_MS_NS / `PCM_CLK_NS)
`define PCM_CLR_MIN_SHORT_MS 100
`define PCM_CLR_MIN_LONG_MS 350
`define PCM_CLR_MAX_MS 30000
`define PCM_MS_CNT_W 15

`endif

// file: press_contact_pkg.sv
package press_contact_pkg;
  typedef enum logic [1:0] {
    ST_STOP = 2'b00,
    ST_RUN = 2'b01,
    ST_BYPASS = 2'b10,
    ST_FAULT = 2'b11
  } mon_state_e;
endpackage

// file: clear_pulse_if.sv
interface clear_pulse_if;
  logic level;
  logic min_long;
  logic accept;
  modport checker_side (input level, input min_long, output accept);
  modport monitor_side (output level, output min_long, input accept);
endinterface

// file: in_sync.sv
module in_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      logic s1_ff, s2_ff, s3_ff, out_ff;
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          s1_ff <= 1'b0;
          s2_ff <= 1'b0;
          s3_ff <= 1'b0;
          out_ff <= 1'b0;
        end else begin
          s1_ff <= din[i];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          // a change counts once the last two stages agree
          if (s2_ff == s3_ff) begin
            out_ff <= s3_ff;
          end
        end
      end
      assign dout[i] = out_ff;
    end
  endgenerate
endmodule

// file: clear_pulse_check.sv
`include "press_contact_regs.svh"

module clear_pulse_check #(
  parameter int TICK_CYCLES = `PCM_TICK_CYCLES
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // clear pulse
  clear_pulse_if.checker_side cp
);
  localparam logic [`PCM_MS_CNT_W-1:0] MIN_SHORT =
    `PCM_MS_CNT_W'(`PCM_CLR_MIN_SHORT_MS);
  localparam logic [`PCM_MS_CNT_W-1:0] MIN_LONG =
    `PCM_MS_CNT_W'(`PCM_CLR_MIN_LONG_MS);
  localparam logic [`PCM_MS_CNT_W-1:0] MAX_MS =
    `PCM_MS_CNT_W'(`PCM_CLR_MAX_MS);

  logic [31:0] div_ff;
  logic [`PCM_MS_CNT_W-1:0] ms_ff;
  logic level_q_ff, accept_ff;
  wire ms_tick = (div_ff == 32'(TICK_CYCLES - 1));
  wire fell = level_q_ff & ~cp.level;
  wire [`PCM_MS_CNT_W-1:0] min_ms = cp.min_long ? MIN_LONG : MIN_SHORT;
  // too long a pulse saturates above the maximum and is never accepted
  wire saturated = (ms_ff > MAX_MS);
  wire width_ok = (ms_ff >= min_ms) && !saturated;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_ff <= 32'h0000_0000;
    end else if (!cp.level || ms_tick) begin
      div_ff <= 32'h0000_0000;
    end else begin
      div_ff <= div_ff + 32'h0000_0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_ff <= '0;
      level_q_ff <= 1'b0;
      accept_ff <= 1'b0;
    end else begin
      level_q_ff <= cp.level;
      accept_ff <= fell & width_ok;
      if (!cp.level) begin
        ms_ff <= '0;
      end else if (ms_tick && !saturated) begin
        ms_ff <= ms_ff + 1'b1;
      end
    end
  end

  assign cp.accept = accept_ff;

  a_short_ignored: assert property (@(posedge hclk)
    disable iff (!hresetn)
    fell && ms_ff < min_ms |=> !accept_ff)
    else $error("clear pulse shorter than minimum accepted");
  a_long_ignored: assert property (@(posedge hclk)
    disable iff (!hresetn)
    fell && saturated |=> !accept_ff)
    else $error("clear pulse longer than maximum accepted");
  c_clear_ok: cover property (@(posedge hclk) disable iff (!hresetn)
    accept_ff);
endmodule

// file: press_contact_monitor.sv
// Overview of operation
// - ordering violation drops enable, sets sequence fault
// - run-on fault unless motor-go confirms drive
// - bypass without fault: enable low, checks paused
// - bypass with fault still accepts clear
// - bypass release restarts like entering run
// - universal needs head switch only
// - universal rising phase only with foot switch
// - universal run-on check needs stop-zone switch
// - no optional switches: head phase only
// - foot pulses: exactly one or zero-two
// - optional inputs and fault flag selectable
// - clear pulse between minimum and thirty seconds
// - enable high while run set, no fault and not bypassed
// - fault: enable low, fault, pending high
// - enable low while supervision bypassed
// - without clear input, stop-run clears faults
// - eccentric phases from stop-zone and rising-stroke
// - universal phases from head and foot
// - fault forces both phase outputs low
`include "press_contact_regs.svh"

module press_contact_monitor
  import press_contact_pkg::*;
#(
  parameter int TICK_CYCLES = `PCM_TICK_CYCLES
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // cam switch, clear and bypass pins
  input wire logic stop_zone_sw,
  input wire logic rise_stroke_sw,
  input wire logic head_position_switch,
  input wire logic foot_position_switch,
  input wire logic clear_in,
  input wire logic bypass_in,
  // drive command from cycle control logic
  input wire logic motor_go,
  // phase and fault outputs
  output logic enable,
  output logic head_phase,
  output logic rise_phase,
  output logic seq_fault,
  output logic runon_fault,
  output logic clear_pending,
  output logic fault_flag
);
  // register bus
  logic [`PCM_CTRL_W-1:0] ctrl_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff, hresp_ff;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [31:0] status;

  wire addr_ok = hsel & htrans[1] & hready;
  wire [7:0] addr_lo = haddr[7:0];
  wire rd_ctrl = addr_ok & ~hwrite & (addr_lo == `PCM_CTRL_OFS);
  wire rd_stat = addr_ok & ~hwrite & (addr_lo == `PCM_STATUS_OFS);
  wire wr_ctrl = wr_pend_ff & (wr_addr_ff == `PCM_CTRL_OFS);
  wire [31:0] nxt_hrdata = rd_ctrl ? {{(32-`PCM_CTRL_W){1'b0}}, ctrl_ff} :
                           rd_stat ? status : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      wr_pend_ff <= addr_ok & hwrite;
      wr_addr_ff <= addr_lo;
      hrdata_ff <= nxt_hrdata;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= `PCM_CTRL_W'(`PCM_CTRL_RST);
    end else if (wr_ctrl) begin
      ctrl_ff <= hwdata[`PCM_CTRL_W-1:0];
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;

  // configuration
  wire run = ctrl_ff[`PCM_CTRL_RUN];
  wire univ = ctrl_ff[`PCM_CTRL_UNIV];
  wire sz_en = ctrl_ff[`PCM_CTRL_SZ_EN];
  wire foot_en = ctrl_ff[`PCM_CTRL_FOOT_EN];
  wire clr_en = ctrl_ff[`PCM_CTRL_CLR_EN];
  wire byp_en = ctrl_ff[`PCM_CTRL_BYP_EN];
  wire flag_en = ctrl_ff[`PCM_CTRL_FLAG_EN];
  wire ppc_range = ctrl_ff[`PCM_CTRL_PPC_RANGE];

  // input sampling
  logic [5:0] pins_s;
  logic sz_q_ff, rs_q_ff, hd_q_ff, ft_q_ff, mg_q_ff;

  in_sync #(.W(6)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .din({bypass_in, clear_in, foot_position_switch,
          head_position_switch, rise_stroke_sw, stop_zone_sw}),
    .dout(pins_s)
  );

  wire sz = pins_s[0];
  wire rs = pins_s[1];
  wire hd = pins_s[2];
  wire ft = pins_s[3] & foot_en;
  wire byp_act = pins_s[5] & byp_en;

  clear_pulse_if cp ();
  assign cp.level = pins_s[4] & clr_en;
  assign cp.min_long = ctrl_ff[`PCM_CTRL_MIN_LONG];

  clear_pulse_check #(.TICK_CYCLES(TICK_CYCLES)) u_clear (
    .hclk(hclk),
    .hresetn(hresetn),
    .cp(cp.checker_side)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sz_q_ff <= 1'b0;
      rs_q_ff <= 1'b0;
      hd_q_ff <= 1'b0;
      ft_q_ff <= 1'b0;
      mg_q_ff <= 1'b0;
    end else begin
      sz_q_ff <= sz;
      rs_q_ff <= rs;
      hd_q_ff <= hd;
      ft_q_ff <= ft;
      mg_q_ff <= motor_go;
    end
  end

  // supervision
  mon_state_e state_ff, nxt_state;
  logic armed_ff, started_ff, runon_ok_ff, foot_used_ff;
  logic [1:0] foot_cnt_ff;
  logic head_ff, rise_ff, seqf_ff, runf_ff, en_ff, pend_ff, flag_ff;

  // edges count only when the previous cycle was also supervised
  wire live = (state_ff == ST_RUN) & armed_ff & run & ~byp_act;
  wire sz_r = live & sz & ~sz_q_ff;
  wire sz_f = live & ~sz & sz_q_ff;
  wire rs_r = live & rs & ~rs_q_ff;
  wire rs_f = live & ~rs & rs_q_ff;
  wire hd_r = live & hd & ~hd_q_ff;
  wire hd_f = live & ~hd & hd_q_ff;
  wire ft_r = live & ft & ~ft_q_ff;
  wire ft_f = live & ~ft & ft_q_ff;
  wire mg_r = live & motor_go & ~mg_q_ff;

  wire ecc_seq = ~univ & ((sz_r & ~rs_q_ff) |
                          (sz_f & rs_q_ff) |
                          (rs_r & sz_q_ff) |
                          (rs_f & ~sz_q_ff));
  // foot pulses counted per cycle, checked when head switch falls
  wire foot_bad = ppc_range ? (foot_cnt_ff > 2'd2) : (foot_cnt_ff != 2'd1);
  wire uni_seq = univ & foot_en & started_ff & hd_f & foot_bad;
  wire seq_now = ecc_seq | uni_seq;
  wire runon_chk = ~univ | sz_en;
  wire runon_now = runon_chk & sz_f & ~runon_ok_ff & ~motor_go;
  wire fault_now = seq_now | runon_now;
  wire clr_ok = clr_en & cp.accept;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_STOP: begin
        if (run) begin
          nxt_state = byp_act ? ST_BYPASS : ST_RUN;
        end
      end
      ST_RUN: begin
        if (byp_act) begin
          nxt_state = ST_BYPASS;
        end else if (fault_now) begin
          nxt_state = ST_FAULT;
        end
      end
      ST_BYPASS: begin
        if (!byp_act) begin
          nxt_state = ST_RUN;
        end
      end
      ST_FAULT: begin
        if (clr_ok) begin
          nxt_state = byp_act ? ST_BYPASS : ST_RUN;
        end
      end
      default: nxt_state = ST_STOP;
    endcase
    if (!run) begin
      nxt_state = ST_STOP;
    end
  end

  wire nxt_run = (nxt_state == ST_RUN);
  wire nxt_fault = (nxt_state == ST_FAULT);
  wire nxt_seqf = nxt_fault & (seqf_ff | seq_now);
  wire nxt_runf = nxt_fault & (runf_ff | (runon_now & ~seq_now));
  wire ecc_rise = rs_r ? 1'b1 : (sz_r ? 1'b0 : rise_ff);
  wire uni_rise = (ft_r & ~foot_used_ff) ? 1'b1 :
                  ((hd_f | ft_f) ? 1'b0 : rise_ff);
  wire nxt_head = nxt_run & (univ ? ~hd : sz);
  wire nxt_rise = nxt_run & (univ ? (foot_en & uni_rise) : ecc_rise);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= ST_STOP;
      armed_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      armed_ff <= nxt_run & (state_ff == ST_RUN);
    end
  end

  // run-on confirmation and foot pulse bookkeeping
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      runon_ok_ff <= 1'b0;
      started_ff <= 1'b0;
      foot_used_ff <= 1'b0;
      foot_cnt_ff <= 2'd0;
    end else if (!live) begin
      runon_ok_ff <= 1'b0;
      started_ff <= 1'b0;
      foot_used_ff <= 1'b0;
      foot_cnt_ff <= 2'd0;
    end else begin
      if (mg_r & head_ff) begin
        runon_ok_ff <= 1'b1;
      end else if (sz_f) begin
        runon_ok_ff <= 1'b0;
      end
      if (hd_f) begin
        started_ff <= 1'b1;
        // a foot pulse on the head fall belongs to the new cycle
        foot_used_ff <= ft_r;
        foot_cnt_ff <= {1'b0, ft_r};
      end else if (ft_r) begin
        foot_used_ff <= 1'b1;
        if (foot_cnt_ff != 2'd3) begin
          foot_cnt_ff <= foot_cnt_ff + 2'd1;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_ff <= 1'b0;
      head_ff <= 1'b0;
      rise_ff <= 1'b0;
      seqf_ff <= 1'b0;
      runf_ff <= 1'b0;
      pend_ff <= 1'b0;
      flag_ff <= 1'b0;
    end else begin
      en_ff <= nxt_run;
      head_ff <= nxt_head;
      rise_ff <= nxt_rise;
      seqf_ff <= nxt_seqf;
      runf_ff <= nxt_runf;
      pend_ff <= nxt_fault;
      flag_ff <= flag_en & nxt_fault;
    end
  end

  assign enable = en_ff;
  assign head_phase = head_ff;
  assign rise_phase = rise_ff;
  assign seq_fault = seqf_ff;
  assign runon_fault = runf_ff;
  assign clear_pending = pend_ff;
  assign fault_flag = flag_ff;

  assign status = {17'h0_0000, pins_s[5:0], state_ff, flag_ff, pend_ff,
                   runf_ff, seqf_ff, rise_ff, head_ff, en_ff};

  // checks
  a_seq_drop: assert property (@(posedge hclk)
    disable iff (!hresetn)
    run && live && seq_now |=> !enable && seq_fault && clear_pending)
    else $error("sequence fault did not drop enable");
  a_runon_drop: assert property (@(posedge hclk)
    disable iff (!hresetn)
    run && live && runon_now && !seq_now |=> !enable && runon_fault)
    else $error("run-on fault did not drop enable");
  a_bypass_hold: assert property (@(posedge hclk)
    disable iff (!hresetn)
    state_ff == ST_BYPASS |-> !enable && !seq_fault && !runon_fault)
    else $error("enable or fault set while bypassed");
  a_bypass_clear: assert property (@(posedge hclk)
    disable iff (!hresetn)
    state_ff == ST_FAULT && run && byp_act && clr_ok
    |=> state_ff == ST_BYPASS ##1 !clear_pending)
    else $error("clear refused during bypass");
  a_bypass_end: assert property (@(posedge hclk)
    disable iff (!hresetn)
    state_ff == ST_BYPASS && run && !byp_act |=> enable)
    else $error("enable not restored after bypass");
  a_enable_ok: assert property (@(posedge hclk)
    disable iff (!hresetn)
    state_ff == ST_RUN && run && !byp_act && !fault_now |=> enable)
    else $error("enable low without fault");
  a_fault_phase: assert property (@(posedge hclk)
    disable iff (!hresetn)
    clear_pending |-> !head_phase && !rise_phase && !enable)
    else $error("phase outputs active during fault");
  a_no_clear: assert property (@(posedge hclk)
    disable iff (!hresetn)
    state_ff == ST_FAULT && run && !clr_en |=> clear_pending)
    else $error("fault left without clear input");
  a_rise_foot: assert property (@(posedge hclk)
    disable iff (!hresetn)
    univ && !foot_en |=> !rise_phase)
    else $error("rising phase without foot switch");
  c_seq_fault: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(seq_fault));
  c_runon_fault: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(runon_fault));
  c_bypass_back: cover property (@(posedge hclk) disable iff (!hresetn)
    state_ff == ST_BYPASS ##1 state_ff == ST_RUN);
endmodule

// file: cam_model.sv
module cam_model (
  // clock
  input wire logic hclk,
  // cam switches and drive command
  output logic stop_zone_sw,
  output logic rise_stroke_sw,
  output logic head_position_switch,
  output logic foot_position_switch,
  output logic motor_go
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    stop_zone_sw = 1'b1;
    rise_stroke_sw = 1'b0;
    head_position_switch = 1'b1;
    foot_position_switch = 1'b0;
    motor_go = 1'b0;
  end

  // one line change, then room for the three-stage synchroniser
  task automatic set_pin(input int idx, input logic val);
    @(posedge hclk);
    case (idx)
      0: stop_zone_sw <= val;
      1: rise_stroke_sw <= val;
      2: head_position_switch <= val;
      3: foot_position_switch <= val;
      default: motor_go <= val;
    endcase
    repeat (8) @(posedge hclk);
  endtask

  // drive command comes from cycle control logic, never from a pin
  task automatic drive(input logic val);
    set_pin(4, val);
  endtask
endmodule

// file: tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 2;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic clear_in, bypass_in, enable, head_phase, rise_phase;
  logic seq_fault, runon_fault, clear_pending, fault_flag;
  logic sz, rs, hd, ft, mgo;
  int err_count, total_checks;

  assign hready = hreadyout;

  cam_model cams (.hclk(hclk), .stop_zone_sw(sz), .rise_stroke_sw(rs),
    .head_position_switch(hd), .foot_position_switch(ft), .motor_go(mgo));

  press_contact_monitor #(.TICK_CYCLES(TICK)) DUT (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .stop_zone_sw(sz), .rise_stroke_sw(rs), .head_position_switch(hd),
    .foot_position_switch(ft), .clear_in(clear_in), .bypass_in(bypass_in),
    .motor_go(mgo), .enable(enable), .head_phase(head_phase),
    .rise_phase(rise_phase), .seq_fault(seq_fault),
    .runon_fault(runon_fault), .clear_pending(clear_pending),
    .fault_flag(fault_flag));

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // order: enable head rise seq runon pending flag
  task automatic chk_out(input logic [6:0] exp);
    chk({25'h0, enable, head_phase, rise_phase, seq_fault, runon_fault,
      clear_pending, fault_flag}, {25'h0, exp});
  endtask

  task automatic bus(input logic wr, input logic [31:0] a,
    input logic [31:0] wd, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'b010;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
    repeat (8) @(posedge hclk);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    chk(r & 32'h0000_01FF, exp);
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
  endtask

  task automatic pulse(input int ticks);
    @(posedge hclk);
    clear_in <= 1'b1;
    repeat (ticks * TICK) @(posedge hclk);
    clear_in <= 1'b0;
    repeat (12) @(posedge hclk);
  endtask

  task automatic t_reset();
    chk_out(7'h00);
    rd_chk(32'h0000_0000, 32'h0000_0000);
    rd_chk(32'h0000_0004, 32'h0000_0000);
    rd_chk(32'h0000_0008, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_stroke();
    wr(32'h0000_0000, 32'h0000_0071);
    chk_out(7'b1100000);
    cams.drive(1'b1);
    cams.set_pin(0, 1'b0);
    chk_out(7'b1000000);
    cams.set_pin(1, 1'b1);
    chk_out(7'b1010000);
    cams.set_pin(0, 1'b1);
    chk_out(7'b1100000);
    cams.drive(1'b0);
    cams.set_pin(1, 1'b0);
    chk_out(7'b1100000);
    cams.set_pin(0, 1'b0);
    chk_out(7'b0000111);
    $display("test stroke done");
  endtask

  task automatic t_clear();
    pulse(95);
    chk_out(7'b0000111);
    pulse(30010);
    chk_out(7'b0000111);
    pulse(105);
    chk_out(7'b1000000);
    $display("test clear done");
  endtask

  task automatic t_seq();
    cams.set_pin(0, 1'b1);
    chk_out(7'b0001011);
    rd_chk(32'h0000_0004, 32'h0000_01E8);
    $display("test sequence done");
  endtask

  task automatic t_bypass();
    @(posedge hclk);
    bypass_in <= 1'b1;
    repeat (8) @(posedge hclk);
    pulse(105);
    chk_out(7'b0000000);
    cams.set_pin(1, 1'b1);
    chk_out(7'b0000000);
    @(posedge hclk);
    bypass_in <= 1'b0;
    repeat (8) @(posedge hclk);
    chk_out(7'b1100000);
    $display("test bypass done");
  endtask

  task automatic t_restart();
    wr(32'h0000_0000, 32'h0000_0041);
    cams.set_pin(0, 1'b0);
    chk_out(7'b0001011);
    pulse(105);
    chk_out(7'b0001011);
    wr(32'h0000_0000, 32'h0000_0040);
    wr(32'h0000_0000, 32'h0000_0041);
    chk_out(7'b1000000);
    $display("test restart done");
  endtask

  task automatic t_univ();
    wr(32'h0000_0000, 32'h0000_0000);
    wr(32'h0000_0000, 32'h0000_0003);
    chk_out(7'b1000000);
    cams.set_pin(2, 1'b0);
    chk_out(7'b1100000);
    cams.set_pin(3, 1'b1);
    chk_out(7'b1100000);
    cams.set_pin(2, 1'b1);
    chk_out(7'b1000000);
    $display("test universal done");
  endtask

  task automatic t_options();
    wr(32'h0000_0000, 32'h0000_0000);
    cams.set_pin(3, 1'b0);
    wr(32'h0000_0000, 32'h0000_000B);
    chk_out(7'b1000000);
    cams.set_pin(2, 1'b0);
    cams.set_pin(2, 1'b1);
    cams.set_pin(3, 1'b1);
    chk_out(7'b1010000);
    cams.set_pin(3, 1'b0);
    chk_out(7'b1000000);
    cams.set_pin(2, 1'b0);
    chk_out(7'b1100000);
    cams.set_pin(2, 1'b1);
    cams.set_pin(2, 1'b0);
    chk_out(7'b0001010);
    wr(32'h0000_0000, 32'h0000_0000);
    wr(32'h0000_0000, 32'h0000_008B);
    cams.set_pin(2, 1'b1);
    cams.set_pin(2, 1'b0);
    cams.set_pin(2, 1'b1);
    cams.set_pin(2, 1'b0);
    chk_out(7'b1100000);
    wr(32'h0000_0000, 32'h0000_0000);
    wr(32'h0000_0000, 32'h0000_0117);
    cams.set_pin(0, 1'b1);
    cams.set_pin(0, 1'b0);
    chk_out(7'b0000110);
    pulse(200);
    chk_out(7'b0000110);
    pulse(360);
    chk_out(7'b1100000);
    $display("test options done");
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    err_count = 0;
    total_checks = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    clear_in = 1'b0;
    bypass_in = 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_stroke();
    t_clear();
    t_seq();
    t_bypass();
    t_restart();
    t_univ();
    t_options();
    wrap_up();
  end

  // the long clear pulse alone needs about 60000 cycles
  initial begin
    repeat (90000) @(posedge hclk);
    err_count++;
    wrap_up();
  end
endmodule
